// ---- inc/strap_cfg_defs.vh ----
// Constants for the management port strap loader.
// Assumes inclusion by bare name from the design file.
`ifndef STRAP_CFG_DEFS_VH
`define STRAP_CFG_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_CFG_ADDR 4'h0
`define REG_CTRL_ADDR 4'h1
`define REG_STAT_ADDR 4'h2
`define REG_MASK_ADDR 4'h3

// ----------------------------------------
// Configuration word field positions
// ----------------------------------------
`define CFG_SPEED_LSB 0
`define CFG_IFACE_LSB 2
`define CFG_DUPLEX_BIT 4
`define CFG_LINK_BIT 5
`define CFG_RXPAUSE_BIT 6
`define CFG_TXPAUSE_BIT 7
`define CFG_REF25_BIT 8
`define CFG_REF50_BIT 9
`define CFG_LOOPACT_BIT 10
`define CFG_SPEED_BAD_BIT 11

// ----------------------------------------
// Encodings
// ----------------------------------------
`define SPEED_10M 2'h0
`define SPEED_100M 2'h1
`define SPEED_1000M 2'h2
`define SPEED_ILLEGAL 2'h3
`define IFACE_RGMII 2'h0
`define IFACE_MII 2'h1
`define IFACE_REVMII 2'h2
`define IFACE_GMII 2'h3

// ----------------------------------------
// Status bits and reset values
// ----------------------------------------
`define STAT_LOOP_BIT 0
`define STAT_CAPTURE_BIT 1
`define STAT_W 2
`define STAT_RST 2'h0
`define MASK_RST 2'h0
`define CFG_RST 12'h000
`define SETTLE_CYCLES 4'h3

`endif

// ---- hw/mgmt_port_strap_config.v ----
// Strap capture for the in-band management port, with status, mask and interrupt.
// Assumes straps synchronous to ref_clk and stable while rst is high and shortly after.
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "strap_cfg_defs.vh"

// How it works
// - Two-bit speed strap: 00 10M, 01 100M, 10 1000M; 11 flagged illegal.
// - Two-bit interface strap: 00 RGMII, 01 MII, 10 reverse MII, 11 GMII.
// - Duplex strap 0 gives half duplex, 1 gives full duplex.
// - Receive pause honoured only when its strap is 1.
// - Transmit pause allowed only when its strap is 1.
// - Captured strap 1 drives the 25 MHz reference out of its pin.
// - Captured strap 1 drives the 50 MHz reference out of its pin.
// - Loop detection runs only while the activation input is high.
// - Loop-found output asserted one cycle after loop_seen while detection is on; not held.
module mgmt_port_strap_config (
    // Clock, reset, enable
    input wire ref_clk,
    input wire rst,
    input wire clk_en,
    // Strap inputs
    input wire [1:0] mgmt_port_speed_strap,
    input wire [1:0] mgmt_port_iface_strap,
    input wire mgmt_port_duplex_strap,
    input wire mgmt_port_link_strap,
    input wire mgmt_rx_pause_cap_strap,
    input wire mgmt_tx_pause_cap_strap,
    input wire ref25_out_enable_strap,
    input wire ref50_out_enable_strap,
    // Loop detection
    input wire loop_detect_activate,
    input wire loop_seen,
    output reg loop_found,
    // Reference clocks from the clock generator
    input wire ref25_clk_in,
    input wire ref50_clk_in,
    // Shared pins: out, enable
    output wire ref25_clock_out,
    output wire ref25_clock_oe,
    output wire ref50_clock_out,
    output wire ref50_clock_oe,
    // Captured configuration
    output reg [1:0] port_speed,
    output reg port_speed_bad,
    output reg [1:0] port_iface,
    output reg port_full_duplex,
    output reg port_link_up,
    output reg rx_pause_enable,
    output reg tx_pause_enable,
    output reg loop_detect_on,
    output reg config_valid,
    // Register port
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // Interrupt
    output wire irq
);

    // ----------------------------------------
    // Capture sequencing
    // ----------------------------------------
    localparam ST_SETTLE = 2'h0;
    localparam ST_CAPTURE = 2'h1;
    localparam ST_HOLD = 2'h2;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [3:0] settle_q;
    reg [3:0] settle_d;
    reg ref25_en_q;
    reg ref50_en_q;
    reg loop_ctl_q;
    reg [`STAT_W-1:0] stat_q;
    reg [`STAT_W-1:0] mask_q;
    reg [`STAT_W-1:0] stat_set;
    reg capture_now;
    reg loop_found_prev_q;
    wire [11:0] cfg_word;
    localparam [`STAT_W-1:0] STAT_RST_V = `STAT_RST;
    genvar gi;

    always @* begin
        state_d = state_q;
        settle_d = settle_q;
        capture_now = 1'b0;
        case (state_q)
            ST_SETTLE: begin
                if (settle_q == `SETTLE_CYCLES) begin
                    state_d = ST_CAPTURE;
                end else begin
                    settle_d = settle_q + 4'h1;
                end
            end
            ST_CAPTURE: begin
                capture_now = 1'b1;
                state_d = ST_HOLD;
            end
            ST_HOLD: begin
                state_d = ST_HOLD;
            end
            default: begin
                state_d = ST_SETTLE;
                settle_d = 4'h0;
            end
        endcase
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_SETTLE;
            settle_q <= 4'h0;
        end else if (clk_en) begin
            state_q <= state_d;
            settle_q <= settle_d;
        end
    end

    // ----------------------------------------
    // Strap capture, once after reset release
    // ----------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            port_speed <= `SPEED_1000M;
            port_speed_bad <= 1'b0;
            port_iface <= `IFACE_RGMII;
            port_full_duplex <= 1'b0;
            port_link_up <= 1'b0;
            rx_pause_enable <= 1'b0;
            tx_pause_enable <= 1'b0;
            ref25_en_q <= 1'b0;
            ref50_en_q <= 1'b0;
            config_valid <= 1'b0;
        end else if (clk_en && capture_now) begin
            port_speed <= mgmt_port_speed_strap;
            port_speed_bad <= (mgmt_port_speed_strap == `SPEED_ILLEGAL);
            port_iface <= mgmt_port_iface_strap;
            port_full_duplex <= mgmt_port_duplex_strap;
            port_link_up <= mgmt_port_link_strap;
            rx_pause_enable <= mgmt_rx_pause_cap_strap;
            tx_pause_enable <= mgmt_tx_pause_cap_strap;
            ref25_en_q <= ref25_out_enable_strap;
            ref50_en_q <= ref50_out_enable_strap;
            config_valid <= 1'b1;
        end
    end

    // ----------------------------------------
    // Shared clock pins
    // ----------------------------------------
    assign ref25_clock_oe = ref25_en_q;
    assign ref25_clock_out = ref25_en_q & ref25_clk_in;
    assign ref50_clock_oe = ref50_en_q;
    assign ref50_clock_out = ref50_en_q & ref50_clk_in;

    // ----------------------------------------
    // Loop detection
    // ----------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            loop_detect_on <= 1'b0;
            loop_found <= 1'b0;
            loop_found_prev_q <= 1'b0;
        end else if (clk_en) begin
            loop_detect_on <= loop_detect_activate & loop_ctl_q;
            loop_found <= loop_detect_on & loop_seen;
            loop_found_prev_q <= loop_found;
        end
    end

    // ----------------------------------------
    // Status events
    // ----------------------------------------
    always @* begin
        stat_set = {`STAT_W{1'b0}};
        stat_set[`STAT_LOOP_BIT] = loop_found & ~loop_found_prev_q;
        stat_set[`STAT_CAPTURE_BIT] = capture_now;
    end

    assign cfg_word = {port_speed_bad, loop_detect_on, ref50_en_q, ref25_en_q,
                       tx_pause_enable, rx_pause_enable, port_link_up,
                       port_full_duplex, port_iface, port_speed};

    // ----------------------------------------
    // Sticky status bits, set wins over clear
    // ----------------------------------------
    generate
        for (gi = 0; gi < `STAT_W; gi = gi + 1) begin : g_stat
            always @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    stat_q[gi] <= STAT_RST_V[gi];
                end else if (clk_en) begin
                    if (reg_wr && reg_addr == `REG_STAT_ADDR && reg_wdata[gi]) begin
                        stat_q[gi] <= stat_set[gi];
                    end else begin
                        stat_q[gi] <= stat_q[gi] | stat_set[gi];
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mask_q <= `MASK_RST;
            loop_ctl_q <= 1'b1;
            reg_rdata <= 32'h0000_0000;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == `REG_CTRL_ADDR) begin
                loop_ctl_q <= reg_wdata[0];
            end
            if (reg_wr && reg_addr == `REG_MASK_ADDR) begin
                mask_q <= reg_wdata[`STAT_W-1:0];
            end
            reg_rdata <= 32'h0000_0000;
            if (reg_rd) begin
                case (reg_addr)
                    `REG_CFG_ADDR: reg_rdata <= {20'h00000, cfg_word};
                    `REG_CTRL_ADDR: reg_rdata <= {30'h00000000, config_valid, loop_ctl_q};
                    `REG_STAT_ADDR: reg_rdata <= {30'h00000000, stat_q};
                    `REG_MASK_ADDR: reg_rdata <= {30'h00000000, mask_q};
                    default: reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign irq = |(stat_q & mask_q);

endmodule // mgmt_port_strap_config
`default_nettype wire

// ---- verification/strap_board.sv ----
// Board strap resistors and free reference clock sources.
// Assumes the bench picks the strap pattern.
`timescale 1ns/1ps
`default_nettype none
module strap_board (
    // Pattern
    input wire logic [9:0] pat,
    // Straps and clocks
    output logic [9:0] straps,
    output logic ck25,
    output logic ck50
);
    // Never strap speed 11
    assign straps = (pat[1:0] == 2'h3) ? {pat[9:2], 2'h2} : pat;
    initial ck25 = 1'b0;
    initial ck50 = 1'b0;
    always #20 ck25 = ~ck25;
    always #10 ck50 = ~ck50;
endmodule // strap_board
`default_nettype wire

// ---- verification/strap_assertions.sv ----
// Port checks for the strap loader.
// Assumes a bind to the top module.
`timescale 1ns/1ps
`default_nettype none
module strap_checker (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Loop
    input wire logic loop_detect_activate,
    input wire logic loop_seen,
    input wire logic loop_found,
    input wire logic loop_detect_on,
    // Clock pins
    input wire logic ref25_clk_in,
    input wire logic ref50_clk_in,
    input wire logic ref25_clock_out,
    input wire logic ref25_clock_oe,
    input wire logic ref50_clock_out,
    input wire logic ref50_clock_oe,
    // Configuration
    input wire logic [1:0] port_speed,
    input wire logic port_speed_bad,
    input wire logic config_valid
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    property p_bad; port_speed_bad == (port_speed == 2'h3); endproperty
    a_bad: assert property (p_bad) else $error("speed flag wrong");
    property p_c25; ref25_clock_out == (ref25_clock_oe && ref25_clk_in); endproperty
    a_c25: assert property (p_c25) else $error("ref25 pin wrong");
    property p_c50; ref50_clock_out == (ref50_clock_oe && ref50_clk_in); endproperty
    a_c50: assert property (p_c50) else $error("ref50 pin wrong");
    property p_off; !loop_detect_activate |=> !loop_detect_on; endproperty
    a_off: assert property (p_off) else $error("loop detect not off");
    property p_on; loop_detect_activate |=> loop_detect_on; endproperty
    a_on: assert property (p_on) else $error("loop detect not on");
    property p_fnd; (loop_detect_on && loop_seen) [*2] |-> loop_found; endproperty
    a_fnd: assert property (p_fnd) else $error("loop not flagged");
    property p_why; loop_found |-> $past(loop_seen); endproperty
    a_why: assert property (p_why) else $error("loop flagged alone");
    property p_hold;
        config_valid && $past(config_valid) |-> $stable(port_speed) && $stable(ref25_clock_oe);
    endproperty
    a_hold: assert property (p_hold) else $error("capture moved");
endmodule // strap_checker
bind mgmt_port_strap_config strap_checker u_chk (.ref_clk, .rst, .loop_detect_activate,
    .loop_seen, .loop_found, .loop_detect_on, .ref25_clk_in, .ref50_clk_in, .ref25_clock_out,
    .ref25_clock_oe, .ref50_clock_out, .ref50_clock_oe, .port_speed, .port_speed_bad,
    .config_valid);
`default_nettype wire

// ---- verification/mgmt_port_strap_config_tb_top.sv ----
// Bench for the strap loader.
// Assumes the board model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module mgmt_port_strap_config_tb_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic act = 1'b0;
    logic loop_seen = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [9:0] pat = 10'h0;
    logic [9:0] s;
    logic [31:0] rdata;
    logic [1:0] spd, ifc;
    logic ck25, ck50, loop_found, on, config_valid, bad, oe25, oe50, irq, dup, lnk, rxp, txp;
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;
    always #12.5 ref_clk = ~ref_clk;
    strap_board u_board (.pat(pat), .straps(s), .ck25(ck25), .ck50(ck50));
    mgmt_port_strap_config u_dut (.ref_clk, .rst, .clk_en(1'b1),
        .mgmt_port_speed_strap(s[1:0]), .mgmt_port_iface_strap(s[3:2]),
        .mgmt_port_duplex_strap(s[4]), .mgmt_port_link_strap(s[5]),
        .mgmt_rx_pause_cap_strap(s[6]), .mgmt_tx_pause_cap_strap(s[7]),
        .ref25_out_enable_strap(s[8]), .ref50_out_enable_strap(s[9]),
        .loop_detect_activate(act), .loop_seen, .loop_found, .ref25_clk_in(ck25),
        .ref50_clk_in(ck50), .ref25_clock_out(), .ref25_clock_oe(oe25), .ref50_clock_out(),
        .ref50_clock_oe(oe50), .port_speed(spd), .port_speed_bad(bad), .port_iface(ifc),
        .port_full_duplex(dup), .port_link_up(lnk), .rx_pause_enable(rxp),
        .tx_pause_enable(txp), .loop_detect_on(on), .config_valid, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata(rdata), .irq);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic report_and_stop;
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt++;
            report_and_stop;
        end
    end
    initial begin
        logic [9:0] p;
        for (int i = 0; i < 4; i++) begin
            p = {i[0] ? 6'h2a : 6'h15, 2'(3 - i), (i == 3) ? 2'h2 : 2'(i)};
            @(posedge ref_clk);
            pat <= p;
            rst <= 1'b1;
            repeat (6) @(posedge ref_clk);
            rst <= 1'b0;
            repeat (20) if (config_valid !== 1'b1) begin @(posedge ref_clk); #1; end
            chk({txp, rxp, lnk, dup, ifc, spd}, p[7:0]);
            chk({oe50, oe25, bad}, {p[9:8], 1'b0});
            rd(4'h0, {22'h0, p});
            @(posedge ref_clk);
            pat <= ~p;
            rd(4'h0, {22'h0, p});
        end
        @(posedge ref_clk);
        act <= 1'b1;
        loop_seen <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 chk({loop_found, on}, 2'h3);
        rd(4'h2, 32'h3);
        rd(4'h0, {20'h0, 2'h1, p});
        rd(4'h1, 32'h3);
        wr(4'h3, 32'h1);
        #1 chk(irq, 1'b1);
        @(posedge ref_clk);
        loop_seen <= 1'b0;
        wr(4'h2, 32'h1);
        #1 chk(irq, 1'b0);
        rd(4'h2, 32'h2);
        rd(4'hf, 32'h0);
        @(posedge ref_clk);
        act <= 1'b0;
        loop_seen <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 chk({loop_found, on}, 2'h0);
        report_and_stop;
    end
endmodule // mgmt_port_strap_config_tb_top
`default_nettype wire
